// *** pkg/vps_regs.svh ***
`ifndef VPS_REGS_SVH
`define VPS_REGS_SVH
// hot-plug change flag value after reset
`define VPS_HPD_RESET    1'b0
// pin output enables after reset: outputs start floating
`define VPS_OE_RESET     1'b0
// pixel port width per channel
`define VPS_PIX_W        8
// number of colour channels: red, green, blue
`define VPS_CHANNELS     3
// level driven by held-low outputs during standby
`define VPS_HELD_LOW     1'b0
`endif

// *** pkg/vps_pkg.sv ***
`include "vps_regs.svh"
package vps_pkg;
    // power state of the whole digitizer
    typedef enum logic [1:0] {
        VPS_RUN,
        VPS_STANDBY,
        VPS_POWERDOWN
    } vps_mode_t;
    // one colour channel: two pixel ports plus out-of-range bit
    typedef struct packed {
        logic [`VPS_PIX_W-1:0] port_a;
        logic [`VPS_PIX_W-1:0] port_b;
        logic                  overrange;
    } vps_chan_t;
    // outputs that float during standby
    typedef struct packed {
        logic data_clock;
        logic data_enable;
        logic line_sync;
        logic frame_sync;
    } vps_float_t;
    // outputs that are held low during standby
    typedef struct packed {
        logic reference_clock;
        logic composite_sync;
        logic clamp_pulse;
        logic field_identity;
    } vps_low_t;
    // run enables for the internal blocks
    typedef struct packed {
        logic activity_det;
        logic i2c_slave;
        logic sync_sep;
        logic sync_on_green_slicer;
        logic pixel_counter;
        logic converters;
        logic demux;
        logic gain_amps;
        logic clamp_cells;
    } vps_en_t;
endpackage

// *** hw/vps_chan_out.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "vps_regs.svh"
// output stage of one colour channel, registered on the next power state
module vps_chan_out
    import vps_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      rstn,
    input  wire vps_mode_t next_mode,
    input  wire vps_chan_t conv,
    output vps_chan_t      pin,
    output logic           data_oe,
    output logic           ovr_oe
);
    vps_chan_t next_pin;      // next pin values
    logic      next_data_oe;  // next enable of the 16 data bits
    logic      next_ovr_oe;   // next enable of the out-of-range bit

    // data floats outside run; overrange is held low in standby only
    always_comb begin
        next_pin     = conv;
        next_data_oe = 1'b1;
        next_ovr_oe  = 1'b1;
        case (next_mode)
            VPS_RUN: begin
                next_data_oe = 1'b1;
            end
            VPS_STANDBY: begin
                next_pin           = '0;
                next_data_oe       = 1'b0;
                next_pin.overrange = `VPS_HELD_LOW;
            end
            default: begin
                // power-down: every pin floats
                next_pin     = '0;
                next_data_oe = 1'b0;
                next_ovr_oe  = 1'b0;
            end
        endcase
    end

    // register the stage so pins come from flops
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin     <= '0;
            data_oe <= `VPS_OE_RESET;
            ovr_oe  <= `VPS_OE_RESET;
        end else begin
            pin     <= next_pin;
            data_oe <= next_data_oe;
            ovr_oe  <= next_ovr_oe;
        end
    end
endmodule
`default_nettype wire

// *** hw/vps_power_ctrl.sv ***
// Behaviour
// - standby request bit set enters standby
// - power-down pin high powers whole chip down
// - standby keeps activity, i2c, sync, slicer
// - standby halts counter, converters, demux, gain, clamp
// - standby floats pixel, clock, enable, syncs
// - standby keeps hot-plug output driven normally
// - standby holds overrange, refclk, csync, clamp, field low
// - power-down floats all digital pins
// - power-down stops every internal block
// - power-down releases i2c lines; host waits
// - each channel has ports a, b, overrange
// - sync change sets hot-plug; status read clears
`timescale 1ns/1ps
`default_nettype none
`include "vps_regs.svh"
module vps_power_ctrl
    import vps_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rstn,
    input  wire logic                  standby_request_bit,
    input  wire logic                  power_down_pin,
    input  wire logic                  sync_change,
    input  wire logic                  activity_status_second_reg_read,
    input  wire logic                  i2c_sda_pull,
    input  wire vps_chan_t [2:0]       conv,
    input  wire vps_float_t            float_src,
    input  wire vps_low_t              low_src,
    output vps_chan_t [2:0]            pix,
    output logic [2:0]                 pix_oe,
    output logic [2:0]                 ovr_oe,
    output vps_float_t                 float_pin,
    output logic                       float_oe,
    output vps_low_t                   low_pin,
    output logic                       low_oe,
    output logic                       hot_plug_change_out,
    output logic                       hot_plug_oe,
    output logic                       hot_plug_flag,
    output logic                       i2c_sda_out,
    output logic                       i2c_sda_oe,
    output vps_en_t                    block_en,
    output vps_mode_t                  mode
);
    vps_mode_t  next_mode;      // power state chosen from pin and bit
    vps_float_t next_float_pin; // next floating-group values
    logic       next_float_oe;  // next floating-group enable
    vps_low_t   next_low_pin;   // next held-low group values
    logic       next_low_oe;    // next held-low group enable
    logic       next_hpd_flag;  // next hot-plug change flag
    logic       next_hpd_oe;    // next hot-plug pin enable
    logic       next_sda_oe;    // next i2c data enable
    vps_en_t    next_block_en;  // next block enables

    // the pin beats the register bit: a powered-down chip has no live i2c
    always_comb begin
        if (power_down_pin) begin
            next_mode = VPS_POWERDOWN;
        end else if (standby_request_bit) begin
            next_mode = VPS_STANDBY;
        end else begin
            next_mode = VPS_RUN;
        end
    end

    // power state register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mode <= VPS_RUN;
        end else begin
            mode <= next_mode;
        end
    end

    // one output stage per channel, all three alike
    genvar ch;
    generate
        for (ch = 0; ch < `VPS_CHANNELS; ch++) begin : g_chan
            vps_chan_out u_chan (
                .clk       (clk),
                .rstn      (rstn),
                .next_mode (next_mode),
                .conv      (conv[ch]),
                .pin       (pix[ch]),
                .data_oe   (pix_oe[ch]),
                .ovr_oe    (ovr_oe[ch])
            );
        end
    endgenerate

    // control outputs and block enables follow the next state
    always_comb begin
        next_float_pin = float_src;
        next_float_oe  = 1'b1;
        next_low_pin   = low_src;
        next_low_oe    = 1'b1;
        next_block_en  = '1;
        case (next_mode)
            VPS_RUN: begin
                next_block_en = '1;
            end
            VPS_STANDBY: begin
                // detection side stays alive so input changes still report
                next_block_en.activity_det         = 1'b1;
                next_block_en.i2c_slave            = 1'b1;
                next_block_en.sync_sep             = 1'b1;
                next_block_en.sync_on_green_slicer = 1'b1;
                next_block_en.pixel_counter        = 1'b0;
                next_block_en.converters           = 1'b0;
                next_block_en.demux                = 1'b0;
                next_block_en.gain_amps            = 1'b0;
                next_block_en.clamp_cells          = 1'b0;
                next_float_pin = '0;
                next_float_oe  = 1'b0;
                next_low_pin   = '0;
                next_low_oe    = 1'b1;
            end
            default: begin
                next_block_en  = '0;
                next_float_pin = '0;
                next_float_oe  = 1'b0;
                next_low_pin   = '0;
                next_low_oe    = 1'b0;
            end
        endcase
    end

    // hot-plug flag: a change arriving with the clearing read wins;
    // inputs are ignored in power-down since detection is stopped
    always_comb begin
        next_hpd_flag = hot_plug_flag;
        if (mode != VPS_POWERDOWN && activity_status_second_reg_read) begin
            next_hpd_flag = 1'b0;
        end
        if (mode != VPS_POWERDOWN && sync_change) begin
            next_hpd_flag = 1'b1;
        end
        next_hpd_oe = (next_mode != VPS_POWERDOWN);
        // i2c only ever pulls low; released while powered down
        next_sda_oe = i2c_sda_pull && (next_mode != VPS_POWERDOWN);
    end

    // registers for control pins, flag and enables
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            float_pin     <= '0;
            float_oe      <= `VPS_OE_RESET;
            low_pin       <= '0;
            low_oe        <= `VPS_OE_RESET;
            hot_plug_flag <= `VPS_HPD_RESET;
            hot_plug_oe   <= `VPS_OE_RESET;
            i2c_sda_oe    <= `VPS_OE_RESET;
            block_en      <= '0;
        end else begin
            float_pin     <= next_float_pin;
            float_oe      <= next_float_oe;
            low_pin       <= next_low_pin;
            low_oe        <= next_low_oe;
            hot_plug_flag <= next_hpd_flag;
            hot_plug_oe   <= next_hpd_oe;
            i2c_sda_oe    <= next_sda_oe;
            block_en      <= next_block_en;
        end
    end

    // pin mirrors the flag; open-drain data always drives low when enabled
    assign hot_plug_change_out = hot_plug_flag;
    assign i2c_sda_out         = 1'b0;

    // ---- checks ----
    property p_standby_enter;
        @(posedge clk) disable iff (!rstn)
        standby_request_bit && !power_down_pin |=> mode == VPS_STANDBY;
    endproperty
    a_standby_enter: assert property (p_standby_enter) else $error("standby not entered");

    property p_pd_enter;
        @(posedge clk) disable iff (!rstn)
        power_down_pin |=> mode == VPS_POWERDOWN;
    endproperty
    a_pd_enter: assert property (p_pd_enter) else $error("power-down not entered");

    property p_sb_alive;
        @(posedge clk) disable iff (!rstn)
        mode == VPS_STANDBY |-> block_en.activity_det && block_en.i2c_slave
            && block_en.sync_sep && block_en.sync_on_green_slicer;
    endproperty
    a_sb_alive: assert property (p_sb_alive) else $error("standby stopped a live block");

    property p_sb_halt;
        @(posedge clk) disable iff (!rstn)
        mode == VPS_STANDBY |-> !(block_en.pixel_counter || block_en.converters
            || block_en.demux || block_en.gain_amps || block_en.clamp_cells);
    endproperty
    a_sb_halt: assert property (p_sb_halt) else $error("standby left conversion running");

    property p_sb_float;
        @(posedge clk) disable iff (!rstn)
        mode == VPS_STANDBY |-> pix_oe == 3'h0 && !float_oe;
    endproperty
    a_sb_float: assert property (p_sb_float) else $error("standby outputs not floating");

    property p_sb_hpd;
        @(posedge clk) disable iff (!rstn)
        mode == VPS_STANDBY |-> hot_plug_oe && hot_plug_change_out == hot_plug_flag;
    endproperty
    a_sb_hpd: assert property (p_sb_hpd) else $error("hot-plug pin not driven in standby");

    property p_sb_low;
        @(posedge clk) disable iff (!rstn)
        mode == VPS_STANDBY |-> low_oe && low_pin == '0 && ovr_oe == 3'h7
            && !pix[0].overrange && !pix[1].overrange && !pix[2].overrange;
    endproperty
    a_sb_low: assert property (p_sb_low) else $error("standby low group not low");

    property p_pd_hiz;
        @(posedge clk) disable iff (!rstn)
        mode == VPS_POWERDOWN |-> !(|pix_oe || |ovr_oe || float_oe || low_oe || hot_plug_oe);
    endproperty
    a_pd_hiz: assert property (p_pd_hiz) else $error("pin driven in power-down");

    property p_pd_stop;
        @(posedge clk) disable iff (!rstn)
        power_down_pin |=> block_en == '0;
    endproperty
    a_pd_stop: assert property (p_pd_stop) else $error("block running in power-down");

    property p_i2c_release;
        @(posedge clk) disable iff (!rstn)
        power_down_pin |=> !i2c_sda_oe;
    endproperty
    a_i2c_release: assert property (p_i2c_release) else $error("i2c driven in power-down");

    property p_hpd_set;
        @(posedge clk) disable iff (!rstn)
        sync_change && mode != VPS_POWERDOWN |=> hot_plug_flag && hot_plug_change_out;
    endproperty
    a_hpd_set: assert property (p_hpd_set) else $error("change not flagged");

    property p_hpd_clear;
        @(posedge clk) disable iff (!rstn)
        activity_status_second_reg_read && !sync_change && mode != VPS_POWERDOWN
            |=> !hot_plug_flag;
    endproperty
    a_hpd_clear: assert property (p_hpd_clear) else $error("flag not cleared by read");

    // sampled rstn skips the releasing edge, where the flops still hold reset values
    property p_resume;
        @(posedge clk) disable iff (!rstn)
        rstn && !standby_request_bit && !power_down_pin |=> mode == VPS_RUN && pix_oe == 3'h7
            && float_oe && block_en == '1;
    endproperty
    a_resume: assert property (p_resume) else $error("normal operation not resumed");
endmodule
`default_nettype wire

// *** sim/vps_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// far side: i2c host line with its pull-up and a pixel receiver on the red port
module vps_host_model
    import vps_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      rstn,
    input  wire logic      sda_out,
    input  wire logic      sda_oe,
    input  wire vps_chan_t red_pin,
    input  wire logic      red_oe,
    output logic           sda_level,
    output logic [7:0]     red_seen
);
    logic [7:0] red_last; // last value the receiver saw driven

    // pull-up wins whenever the slave lets go, so a released line reads high
    assign sda_level = sda_oe ? sda_out : 1'b1;

    // a floated port must not look like held data, so show the inverse
    assign red_seen = red_oe ? red_pin.port_a : ~red_last;

    // remember the last driven value for the float pattern
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            red_last <= 8'h00;
        end else if (red_oe) begin
            red_last <= red_pin.port_a;
        end
    end
endmodule
`default_nettype wire

// *** sim/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
// self-checking bench for the power-state control
module tb;
    import vps_pkg::*;
    logic            clk = 1'b0;  // 20 MHz
    logic            rstn = 1'b0; // active low
    logic            sb_req = 1'b0; // standby request
    logic            pd = 1'b0;   // power-down pin
    logic            sc = 1'b0;   // sync change pulse
    logic            rd = 1'b0;   // status read pulse
    logic            pull = 1'b0; // slave wants sda low
    vps_chan_t [2:0] conv = '0;    // converter data
    vps_float_t      fsrc = 4'ha;  // floating group sources
    vps_low_t        lsrc = 4'h5;  // held-low group sources
    vps_chan_t [2:0] pix;
    logic [2:0]      pix_oe;
    logic [2:0]      ovr_oe;
    vps_float_t      float_pin;
    logic            float_oe;
    vps_low_t        low_pin;
    logic            low_oe;
    logic            hp_out;
    logic            hp_oe;
    logic            hp_flag;
    logic            sda_out;
    logic            sda_oe;
    logic            sda_level;
    logic [7:0]      red_seen;
    vps_en_t         block_en;
    vps_mode_t       mode;
    int              errors = 0;
    int              checks_done = 0;

    // clock: invert every half period
    always #25 clk = ~clk;

    vps_power_ctrl uut (.clk(clk), .rstn(rstn), .standby_request_bit(sb_req), .power_down_pin(pd),
        .sync_change(sc), .activity_status_second_reg_read(rd), .i2c_sda_pull(pull), .conv(conv),
        .float_src(fsrc), .low_src(lsrc), .pix(pix), .pix_oe(pix_oe), .ovr_oe(ovr_oe),
        .float_pin(float_pin), .float_oe(float_oe), .low_pin(low_pin), .low_oe(low_oe),
        .hot_plug_change_out(hp_out), .hot_plug_oe(hp_oe), .hot_plug_flag(hp_flag),
        .i2c_sda_out(sda_out), .i2c_sda_oe(sda_oe), .block_en(block_en), .mode(mode));

    vps_host_model far (.clk(clk), .rstn(rstn), .sda_out(sda_out), .sda_oe(sda_oe),
        .red_pin(pix[0]), .red_oe(pix_oe[0]), .sda_level(sda_level), .red_seen(red_seen));

    // one comparison; four-state compare so unknowns never match
    task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // wait for the edge that takes the inputs, then let its updates land
    task automatic settle();
        @(posedge clk);
        #1;
    endtask

    // normal conversion with every output driven
    task automatic run_scenario();
        @(posedge clk);
        conv <= {17'h1_5a5a, 17'h0_c3e1, 17'h1_0ff0};
        pull <= 1'b1;
        settle();
        chk("mode", mode, VPS_RUN);
        chk("pix", pix, {17'h1_5a5a, 17'h0_c3e1, 17'h1_0ff0});
        chk("red_seen", red_seen, 8'h87);
        chk("ctrl_pins", {float_pin, low_pin}, 8'ha5);
        chk("pix_oe", {pix_oe, ovr_oe, float_oe, low_oe, hp_oe}, 9'h1ff);
        chk("block_en", block_en, 9'h1ff);
        chk("sda", {sda_oe, sda_level}, 2'b10);
    endtask

    // standby: keep control running, float data group, hold low group
    task automatic standby_scenario();
        @(posedge clk);
        sb_req <= 1'b1;
        settle();
        chk("mode", mode, VPS_STANDBY);
        chk("block_en", block_en, 9'h1e0);
        chk("block_off", block_en[4:0], 5'h00);
        chk("float_oe", {pix_oe, float_oe}, 4'h0);
        chk("low_oe", {ovr_oe, low_oe}, 4'hf);
        chk("low_val", {pix[2].overrange, pix[1].overrange, pix[0].overrange, low_pin}, 7'h00);
        chk("hp_oe", hp_oe, 1'b1);
        chk("sda", sda_oe, 1'b1);
        @(posedge clk);
        sc <= 1'b1;
        @(posedge clk);
        sc <= 1'b0;
        #1;
        chk("hp_set", {hp_flag, hp_out}, 2'b11);
    endtask

    // hot-plug flag: clear by read, set wins when both coincide
    task automatic hotplug_scenario();
        @(posedge clk);
        rd <= 1'b1;
        @(posedge clk);
        sc <= 1'b1;
        #1;
        chk("hp_clr", {hp_flag, hp_out}, 2'b00);
        // read still high at this edge: change and read coincide
        @(posedge clk);
        sc <= 1'b0;
        rd <= 1'b0;
        #1;
        chk("hp_both", {hp_flag, hp_out}, 2'b11);
        @(posedge clk);
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("hp_clr2", hp_flag, 1'b0);
    endtask

    // power-down beats standby; pulses ignored; flag kept; then resume
    task automatic powerdown_scenario();
        @(posedge clk);
        pd <= 1'b1;
        settle();
        chk("mode", mode, VPS_POWERDOWN);
        chk("all_oe", {pix_oe, ovr_oe, float_oe, low_oe, hp_oe}, 9'h000);
        chk("block_en", block_en, 9'h000);
        chk("sda", {sda_oe, sda_level}, 2'b01);
        chk("red_seen", red_seen, 8'h78);
        @(posedge clk);
        sc <= 1'b1;
        @(posedge clk);
        sc <= 1'b0;
        sb_req <= 1'b0;
        settle();
        chk("hp_ignored", hp_flag, 1'b0);
        @(posedge clk);
        pd <= 1'b0;
        settle();
        chk("mode", mode, VPS_RUN);
        chk("resume_oe", {pix_oe, ovr_oe, float_oe, low_oe, hp_oe}, 9'h1ff);
        chk("sda_back", {sda_oe, sda_level}, 2'b10);
    endtask

    // closing report, the single end of the run
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // watchdog: a hang counts as a mismatch
    initial begin
        #2000000;
        errors++;
        give_verdict();
    end

    // main sequence
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        run_scenario();
        standby_scenario();
        hotplug_scenario();
        @(posedge clk);
        sb_req <= 1'b1;
        powerdown_scenario();
        give_verdict();
    end
endmodule
`default_nettype wire
